// ---- hdl/rss_regs.vh ----
`ifndef RSS_REGS_VH
`define RSS_REGS_VH

// Oscillator mode codes carried by the two configuration bits.
`define RSS_MODE_LP        2'h0
`define RSS_MODE_XT        2'h1
`define RSS_MODE_HS        2'h2
`define RSS_MODE_RC        2'h3

// Clock rate in kHz and delay figures in their own units.
`define RSS_CLK_KHZ        40000
`define RSS_POWERUP_DELAY_TIMER_MS        72
// The delay count is 72 ms of 40 MHz clocks, sized to the delay counter.
`define RSS_POWERUP_DELAY_TIMER_CYCLES    22'h2BF200
`define RSS_OST_EDGES      11'h400
`define RSS_OST_W          11
`define RSS_POWERUP_DELAY_TIMER_W         22

// Master clear filter: low level must persist one clock more than this count.
`define RSS_MASTER_CLEAR_PIN_FILT      4'hF
`define RSS_MASTER_CLEAR_PIN_FILT_W    4

// Supply-dip qualification width in ns and its clock count.
`define RSS_DIP_NS         100
`define RSS_DIP_CYCLES     4'h4
`define RSS_DIP_W          4

// Sequencer states.
`define RSS_ST_HOLD        3'h0
`define RSS_ST_POWERUP_DELAY_TIMER        3'h1
`define RSS_ST_OST         3'h2
`define RSS_ST_WAITMC      3'h3
`define RSS_ST_RUN         3'h4

// Reset cause codes reported on reset_cause.
`define RSS_CAUSE_POR      3'h0
`define RSS_CAUSE_MASTER_CLEAR_PIN_RUN 3'h1
`define RSS_CAUSE_MASTER_CLEAR_PIN_SLP 3'h2
`define RSS_CAUSE_WDT_RUN  3'h3
`define RSS_CAUSE_WDT_WAKE 3'h4
`define RSS_CAUSE_DIP      3'h5
`define RSS_CAUSE_INT_WAKE 3'h6

`define RSS_ONE            1'h1
`define RSS_ZERO           1'h0

`endif

// ---- hdl/rss_reset_sequencer.v ----
`include "rss_regs.vh"

module rss_reset_sequencer #(
    parameter [`RSS_POWERUP_DELAY_TIMER_W-1:0] POWERUP_DELAY_TIMER_CYCLES = `RSS_POWERUP_DELAY_TIMER_CYCLES
) (
    // Clock and reset.
    input  wire       clk,
    input  wire       reset_n,
    // Configuration bits.
    input  wire       clock_mode_sel_hi,
    input  wire       clock_mode_sel_lo,
    input  wire       powerup_delay_enable_n,
    input  wire       supply_dip_detect_en,
    // Detector and pin inputs, all asynchronous.
    input  wire       power_rise,
    input  wire       supply_below_threshold,
    input  wire       master_clear_pin_n,
    input  wire       clock_in_pin,
    // Core events, same clock domain.
    input  wire       watchdog_timeout,
    input  wire       sleep_active,
    input  wire       interrupt_wake,
    input  wire       software_set_por_flag,
    // Mode decode outputs.
    output reg        low_power_crystal_mode,
    output reg        crystal_mode,
    output reg        fast_crystal_mode,
    output reg        resistor_capacitor_mode,
    // Reset outputs.
    output reg        core_reset,
    output reg        group_reset_pulse,
    output reg        wake_resume_pulse,
    output reg  [2:0] reset_cause,
    // Status flags.
    output reg        watchdog_expired_flag,
    output reg        sleep_entered_flag,
    output reg        power_on_flag,
    output reg        supply_dip_flag,
    // Master clear pin drive, never used by a watchdog reset.
    output reg        master_clear_pin_out,
    output reg        master_clear_pin_oe
);

    // Synchronised pin levels.
    wire [3:0] sync_out;
    wire       rise_s;
    wire       dip_s;
    wire       master_clear_pin_s;
    wire       clkin_s;

    // Internal state.
    reg [2:0]                 state;          // Sequencer state.
    reg [`RSS_POWERUP_DELAY_TIMER_W-1:0]     powerup_delay_timer_cnt;       // Power-up delay count.
    reg [`RSS_OST_W-1:0]      ost_cnt;        // Clock-in rising edges seen.
    reg                       clkin_d;        // Previous clock-in level.
    reg [`RSS_MASTER_CLEAR_PIN_FILT_W-1:0] master_clear_pin_cnt;      // Master clear low duration.
    reg                       master_clear_pin_low;       // Filtered master clear asserted.
    reg [`RSS_DIP_W-1:0]      dip_cnt;        // Supply-dip duration.
    reg                       dip_active;     // Qualified supply dip.
    reg                       rise_d;         // Previous power-rise level.
    reg                       is_crystal;     // Settle counter applies.

    rss_sync #(
        .W (4)
    ) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .din     ({power_rise, supply_below_threshold, master_clear_pin_n, clock_in_pin}),
        .dout    (sync_out)
    );

    assign rise_s  = sync_out[3];
    assign dip_s   = sync_out[2];
    assign master_clear_pin_s  = sync_out[1];
    assign clkin_s = sync_out[0];

    // Delay enabled either by its own bit or forced by supply-dip enable.
    wire powerup_delay_timer_on = !powerup_delay_enable_n || supply_dip_detect_en;

    // Power-on event is the rising edge of the detector output.
    wire por_event = rise_s && !rise_d;

    // Master clear filter: only a low lasting the full filter span counts.
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            master_clear_pin_cnt <= {`RSS_MASTER_CLEAR_PIN_FILT_W{1'b0}};
            master_clear_pin_low <= `RSS_ZERO;
        end
        else if (master_clear_pin_s)
        begin
            // Pin high clears the filter at once; a glitch never resets.
            master_clear_pin_cnt <= {`RSS_MASTER_CLEAR_PIN_FILT_W{1'b0}};
            master_clear_pin_low <= `RSS_ZERO;
        end
        else if (master_clear_pin_cnt == `RSS_MASTER_CLEAR_PIN_FILT)
        begin
            master_clear_pin_low <= `RSS_ONE;
        end
        else
        begin
            master_clear_pin_cnt <= master_clear_pin_cnt + 1'b1;
        end
    end

    // Supply-dip qualifier: the dip must outlast the minimum width.
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            dip_cnt    <= {`RSS_DIP_W{1'b0}};
            dip_active <= `RSS_ZERO;
        end
        else if (!dip_s || !supply_dip_detect_en)
        begin
            // Circuit disabled or supply good: no dip reset.
            dip_cnt    <= {`RSS_DIP_W{1'b0}};
            dip_active <= `RSS_ZERO;
        end
        else if (dip_cnt == `RSS_DIP_CYCLES)
        begin
            dip_active <= `RSS_ONE;
        end
        else
        begin
            dip_cnt <= dip_cnt + 1'b1;
        end
    end

    // Edge history for power-rise and the oscillator input.
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            rise_d  <= `RSS_ZERO;
            clkin_d <= `RSS_ZERO;
        end
        else
        begin
            rise_d  <= rise_s;
            clkin_d <= clkin_s;
        end
    end

    // Mode decode: exactly one output is high for each code.
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            low_power_crystal_mode  <= `RSS_ONE;
            crystal_mode            <= `RSS_ZERO;
            fast_crystal_mode       <= `RSS_ZERO;
            resistor_capacitor_mode <= `RSS_ZERO;
        end
        else
        begin
            low_power_crystal_mode  <= ({clock_mode_sel_hi, clock_mode_sel_lo} == `RSS_MODE_LP);
            crystal_mode            <= ({clock_mode_sel_hi, clock_mode_sel_lo} == `RSS_MODE_XT);
            fast_crystal_mode       <= ({clock_mode_sel_hi, clock_mode_sel_lo} == `RSS_MODE_HS);
            resistor_capacitor_mode <= ({clock_mode_sel_hi, clock_mode_sel_lo} == `RSS_MODE_RC);
        end
    end

    // Main sequencer. A held reset waits for power and supply, then runs
    // the power-up delay, then the settle counter, then waits for the pin.
    // Group reset and flags, where a cause touches them, are updated at the moment it is taken.
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            state                 <= `RSS_ST_HOLD;
            powerup_delay_timer_cnt              <= {`RSS_POWERUP_DELAY_TIMER_W{1'b0}};
            ost_cnt               <= {`RSS_OST_W{1'b0}};
            is_crystal            <= `RSS_ZERO;
            core_reset            <= `RSS_ONE;
            group_reset_pulse     <= `RSS_ZERO;
            wake_resume_pulse     <= `RSS_ZERO;
            reset_cause           <= `RSS_CAUSE_POR;
            watchdog_expired_flag <= `RSS_ONE;
            sleep_entered_flag    <= `RSS_ONE;
            power_on_flag         <= `RSS_ZERO;
            supply_dip_flag       <= `RSS_ONE;
            master_clear_pin_out  <= `RSS_ZERO;
            master_clear_pin_oe   <= `RSS_ZERO;
        end
        else
        begin
            group_reset_pulse <= `RSS_ZERO;
            wake_resume_pulse <= `RSS_ZERO;
            if (software_set_por_flag)
            begin
                power_on_flag <= `RSS_ONE;
            end
            if (por_event)
            begin
                // Power-on: everything restarts; the POR flag clears.
                state                 <= `RSS_ST_HOLD;
                core_reset            <= `RSS_ONE;
                group_reset_pulse     <= `RSS_ONE;
                reset_cause           <= `RSS_CAUSE_POR;
                watchdog_expired_flag <= `RSS_ONE;
                sleep_entered_flag    <= `RSS_ONE;
                power_on_flag         <= `RSS_ZERO;
                supply_dip_flag       <= `RSS_ONE;
                is_crystal            <= !resistor_capacitor_mode;
            end
            else if (dip_active && !(core_reset && state == `RSS_ST_HOLD))
            begin
                // Supply dip, also during the delay: restart from hold.
                state                 <= `RSS_ST_HOLD;
                core_reset            <= `RSS_ONE;
                group_reset_pulse     <= `RSS_ONE;
                reset_cause           <= `RSS_CAUSE_DIP;
                watchdog_expired_flag <= `RSS_ONE;
                sleep_entered_flag    <= `RSS_ONE;
                supply_dip_flag       <= `RSS_ZERO;
                is_crystal            <= !resistor_capacitor_mode;
            end
            else if (state == `RSS_ST_RUN && master_clear_pin_low)
            begin
                // Master clear: straight to waiting for the pin, no timers.
                state                 <= `RSS_ST_WAITMC;
                core_reset            <= `RSS_ONE;
                group_reset_pulse     <= `RSS_ONE;
                // Only a clear taken in sleep rewrites the flags; in run they stand.
                if (sleep_active)
                begin
                    watchdog_expired_flag <= `RSS_ONE;
                    sleep_entered_flag    <= `RSS_ZERO;
                end
                reset_cause           <= sleep_active ? `RSS_CAUSE_MASTER_CLEAR_PIN_SLP
                                                      : `RSS_CAUSE_MASTER_CLEAR_PIN_RUN;
            end
            else if (state == `RSS_ST_RUN && watchdog_timeout && !sleep_active)
            begin
                // Watchdog reset is internal only; the pin stays undriven.
                state                 <= `RSS_ST_WAITMC;
                core_reset            <= `RSS_ONE;
                group_reset_pulse     <= `RSS_ONE;
                reset_cause           <= `RSS_CAUSE_WDT_RUN;
                watchdog_expired_flag <= `RSS_ZERO;
                sleep_entered_flag    <= `RSS_ONE;
            end
            else if (state == `RSS_ST_RUN && sleep_active
                     && (watchdog_timeout || interrupt_wake))
            begin
                // Wake-up: no group reset, settle counter in crystal modes.
                wake_resume_pulse     <= `RSS_ONE;
                reset_cause           <= watchdog_timeout ? `RSS_CAUSE_WDT_WAKE
                                                          : `RSS_CAUSE_INT_WAKE;
                watchdog_expired_flag <= !watchdog_timeout;
                sleep_entered_flag    <= `RSS_ZERO;
                ost_cnt               <= {`RSS_OST_W{1'b0}};
                if (!resistor_capacitor_mode)
                begin
                    state      <= `RSS_ST_OST;
                    core_reset <= `RSS_ONE;
                    // Release cleared this, so the wake must arm the settle again.
                    is_crystal <= `RSS_ONE;
                end
            end
            else
            begin
                case (state)
                    `RSS_ST_HOLD:
                    begin
                        // Wait for power present and supply above threshold.
                        powerup_delay_timer_cnt <= {`RSS_POWERUP_DELAY_TIMER_W{1'b0}};
                        ost_cnt  <= {`RSS_OST_W{1'b0}};
                        if (rise_s && !dip_active)
                        begin
                            state <= powerup_delay_timer_on ? `RSS_ST_POWERUP_DELAY_TIMER : `RSS_ST_OST;
                        end
                    end
                    `RSS_ST_POWERUP_DELAY_TIMER:
                    begin
                        // The delay holds reset for its whole span.
                        if (powerup_delay_timer_cnt == POWERUP_DELAY_TIMER_CYCLES - 1'b1)
                        begin
                            state <= `RSS_ST_OST;
                        end
                        else
                        begin
                            powerup_delay_timer_cnt <= powerup_delay_timer_cnt + 1'b1;
                        end
                    end
                    `RSS_ST_OST:
                    begin
                        // Count clock-in rising edges; skipped in RC mode.
                        if (!is_crystal || ost_cnt == `RSS_OST_EDGES)
                        begin
                            state <= `RSS_ST_WAITMC;
                        end
                        else if (clkin_s && !clkin_d)
                        begin
                            ost_cnt <= ost_cnt + 1'b1;
                        end
                    end
                    `RSS_ST_WAITMC:
                    begin
                        // Release only with pin high and no dip pending.
                        if (master_clear_pin_s && !dip_active)
                        begin
                            state      <= `RSS_ST_RUN;
                            core_reset <= `RSS_ZERO;
                            is_crystal <= `RSS_ZERO;
                        end
                    end
                    `RSS_ST_RUN:
                    begin
                        core_reset <= `RSS_ZERO;
                    end
                    default:
                    begin
                        state      <= `RSS_ST_HOLD;
                        core_reset <= `RSS_ONE;
                    end
                endcase
            end
        end
    end

endmodule

// ---- hdl/rss_sync.v ----
`include "rss_regs.vh"

// Two-flop synchroniser for asynchronous level inputs.
module rss_sync #(
    parameter W = 4
) (
    // Clock and reset.
    input  wire         clk,
    input  wire         reset_n,
    // Asynchronous level in, synchronised level out.
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);

    reg [W-1:0] stage1;  // First flop, read only by the second.

    // Both flops take a constant on reset so no pin value leaks in.
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            stage1 <= {W{1'b0}};
            dout   <= {W{1'b0}};
        end
        else
        begin
            stage1 <= din;
            dout   <= stage1;
        end
    end

endmodule

// ---- tb/rss_far_side.sv ----
// Far side of the sequencer: supply detectors, master clear pin and oscillator.
module rss_far_side (
    // Bench clock.
    input  wire  clk,
    // Requests from the bench.
    input  wire  supply_up,
    input  wire  dip_req,
    input  wire  clear_req,
    // Pins seen by the sequencer.
    output logic power_rise = 1'b0,
    output logic supply_below_threshold = 1'b0,
    output logic master_clear_pin_n = 1'b0,
    output logic clock_in_pin = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] div = 2'h0; // Divider for the oscillator pin.

    // The oscillator stands still while the supply is down, and runs at a quarter of clk.
    always @(posedge clk)
    begin
        div <= div + 2'h1;
        if (supply_up && div[0])
            clock_in_pin <= ~clock_in_pin;
        power_rise <= supply_up;
        supply_below_threshold <= dip_req;
        // The pin is held low until the supply is up, so start-up waits for it.
        master_clear_pin_n <= supply_up && !clear_req;
    end
endmodule

// ---- tb/rss_reset_sequencer_properties.sv ----
`include "rss_regs.vh"

// Watches the sequencer's ports for timing and status slips.
module rss_seq_props #(
    parameter [`RSS_POWERUP_DELAY_TIMER_W-1:0] POWERUP_DELAY_TIMER_CYCLES = `RSS_POWERUP_DELAY_TIMER_CYCLES
) (
    // Clock and reset.
    input wire       clk,
    input wire       reset_n,
    // Inputs.
    input wire       clock_mode_sel_hi,
    input wire       clock_mode_sel_lo,
    input wire       supply_dip_detect_en,
    input wire       power_rise,
    input wire       supply_below_threshold,
    input wire       master_clear_pin_n,
    input wire       software_set_por_flag,
    // Outputs.
    input wire       low_power_crystal_mode,
    input wire       crystal_mode,
    input wire       fast_crystal_mode,
    input wire       resistor_capacitor_mode,
    input wire       core_reset,
    input wire       group_reset_pulse,
    input wire       wake_resume_pulse,
    input wire [2:0] reset_cause,
    input wire       watchdog_expired_flag,
    input wire       sleep_entered_flag,
    input wire       power_on_flag,
    input wire       master_clear_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    mode_onehot_a: assert property ($onehot({low_power_crystal_mode,
        crystal_mode, fast_crystal_mode, resistor_capacitor_mode})) else $error("mode not one-hot");
    mode_decode_a: assert property ($past(reset_n) |->
        {resistor_capacitor_mode, fast_crystal_mode, crystal_mode, low_power_crystal_mode}
        == (4'h1 << $past({clock_mode_sel_hi, clock_mode_sel_lo}))) else $error("bad mode");
    pin_undriven_a: assert property (!master_clear_pin_oe) else $error("pin driven");
    group_pulse_a: assert property (group_reset_pulse |=> !group_reset_pulse)
        else $error("group pulse too long");
    wake_keeps_regs_a: assert property (wake_resume_pulse |-> !group_reset_pulse &&
        reset_cause inside {`RSS_CAUSE_WDT_WAKE, `RSS_CAUSE_INT_WAKE}) else $error("bad wake");
    wake_settle_a: assert property (wake_resume_pulse && !resistor_capacitor_mode |->
        core_reset [*8]) else $error("wake skipped settle");
    por_flag_set_a: assert property ($rose(power_on_flag) |-> $past(software_set_por_flag))
        else $error("power flag set unasked");
    por_start_a: assert property ($rose(power_rise) |-> ##[1:5] (group_reset_pulse &&
        reset_cause == `RSS_CAUSE_POR && !power_on_flag)) else $error("no power-on reset");
    release_pin_a: assert property ($fell(core_reset) |-> $past(master_clear_pin_n) &&
        $past(master_clear_pin_n, 2) && !$past(supply_below_threshold)) else $error("early release");
    wdt_flags_a: assert property (reset_cause == `RSS_CAUSE_WDT_RUN && group_reset_pulse
        |=> !watchdog_expired_flag && sleep_entered_flag) else $error("bad watchdog flags");
    dip_enable_a: assert property (group_reset_pulse && reset_cause == `RSS_CAUSE_DIP
        |-> $past(supply_dip_detect_en, 2)) else $error("dip reset while disabled");

    wake_seen_c: cover property (wake_resume_pulse);
    dip_seen_c: cover property (group_reset_pulse && reset_cause == `RSS_CAUSE_DIP);
    release_seen_c: cover property ($fell(core_reset));
endmodule

bind rss_reset_sequencer rss_seq_props #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_CYCLES)) props (.clk(clk),
    .reset_n(reset_n), .clock_mode_sel_hi(clock_mode_sel_hi),
    .clock_mode_sel_lo(clock_mode_sel_lo), .supply_dip_detect_en(supply_dip_detect_en),
    .power_rise(power_rise), .supply_below_threshold(supply_below_threshold),
    .master_clear_pin_n(master_clear_pin_n), .software_set_por_flag(software_set_por_flag),
    .low_power_crystal_mode(low_power_crystal_mode), .crystal_mode(crystal_mode),
    .fast_crystal_mode(fast_crystal_mode), .resistor_capacitor_mode(resistor_capacitor_mode),
    .core_reset(core_reset), .group_reset_pulse(group_reset_pulse),
    .wake_resume_pulse(wake_resume_pulse), .reset_cause(reset_cause),
    .watchdog_expired_flag(watchdog_expired_flag), .sleep_entered_flag(sleep_entered_flag),
    .power_on_flag(power_on_flag), .master_clear_pin_oe(master_clear_pin_oe));

// ---- tb/rss_reset_sequencer_tb_top.sv ----
`include "rss_regs.vh"

// Self-checking bench for the reset and start-up sequencer.
module rss_reset_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
$display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end

    localparam [21:0] PW = 22'h32; // Shortened power-up delay keeps the run brief.

    logic       clk = 1'b0;                          // Bench clock.
    logic       reset_n = 1'b0;                      // Block reset.
    logic       sel_hi = 1'b0, sel_lo = 1'b0;        // Mode code.
    logic       dly_n = 1'b0, dip_en = 1'b0;         // Delay and dip enables.
    logic       supply_up = 1'b0, dip_req = 1'b0;    // Supply requests.
    logic       clear_req = 1'b0, wdt = 1'b0;        // Pin and watchdog events.
    logic       slp = 1'b0, iwake = 1'b0, swpor = 1'b0; // Core events.
    wire        p_rise, p_dip, p_clr_n, p_osc;       // Far-side pins.
    wire        lp, xt, hs, rc, core_reset, grp, wake, to_f, pd_f, por_f, dip_f, mc_o, mc_oe;
    wire  [2:0] cause;                               // Reported reset cause.
    wire  [3:0] modes = {rc, hs, xt, lp};            // Mode decode as one vector.
    int         bad_count = 0, num_checks = 0;       // Verdict counters.
    int         gcnt = 0, wcnt = 0;                  // Pulse counts.
    logic [31:0] seed = 32'h3E2DDCE6;                // Random state.
    logic [3:0] tbl [0:5] = '{4'h2, 4'h4, 4'h8, 4'hE, 4'hF, 4'hD}; // Mode, delay_n, dip.

    rss_far_side far (.clk(clk), .supply_up(supply_up), .dip_req(dip_req),
        .clear_req(clear_req), .power_rise(p_rise), .supply_below_threshold(p_dip),
        .master_clear_pin_n(p_clr_n), .clock_in_pin(p_osc));

    rss_reset_sequencer #(.POWERUP_DELAY_TIMER_CYCLES(PW)) dut (.clk(clk), .reset_n(reset_n),
        .clock_mode_sel_hi(sel_hi), .clock_mode_sel_lo(sel_lo), .powerup_delay_enable_n(dly_n),
        .supply_dip_detect_en(dip_en), .power_rise(p_rise), .supply_below_threshold(p_dip),
        .master_clear_pin_n(p_clr_n), .clock_in_pin(p_osc), .watchdog_timeout(wdt),
        .sleep_active(slp), .interrupt_wake(iwake), .software_set_por_flag(swpor),
        .low_power_crystal_mode(lp), .crystal_mode(xt), .fast_crystal_mode(hs),
        .resistor_capacitor_mode(rc), .core_reset(core_reset), .group_reset_pulse(grp),
        .wake_resume_pulse(wake), .reset_cause(cause), .watchdog_expired_flag(to_f),
        .sleep_entered_flag(pd_f), .power_on_flag(por_f), .supply_dip_flag(dip_f),
        .master_clear_pin_out(mc_o), .master_clear_pin_oe(mc_oe));

    initial
    begin
        forever #12.5 clk = ~clk;
    end

    // Counts one-cycle pulses so each is seen exactly once.
    always @(posedge clk)
    begin
        if (grp === 1'b1)
            gcnt <= gcnt + 1;
        if (wake === 1'b1)
            wcnt <= wcnt + 1;
    end

    // Xorshift step for repeatable random values.
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    // Cycles from the power-on pulse to release for one table entry.
    function automatic int exp_delay(input logic [3:0] t);
        return ((!t[1] || t[0]) ? int'(PW) : 0) + ((t[3:2] != `RSS_MODE_RC) ? 4096 : 0);
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Waits for a new group pulse or for release; a spent bound ends the run.
    task automatic wait_until(input int lim, input bit on_grp, input int g, output int c);
        c = 0;
        while ((on_grp ? gcnt == g : core_reset !== 1'b0) && c < lim)
        begin
            tick(1);
            c++;
        end
        if (c >= lim)
        begin
            bad_count++;
            conclude();
        end
    endtask

    // One core event, optionally in sleep, then its cause, flags and pulses.
    task automatic ev(input logic s, input int k, input logic [2:0] ec, input logic [1:0] ef,
                      input bit is_wake);
        int c0;
        int c1;
        int c;
        c0 = gcnt;
        c1 = wcnt;
        slp <= s;
        tick(2);
        if (k == 0)
            wdt <= 1'b1;
        else if (k == 1)
            iwake <= 1'b1;
        else
            clear_req <= 1'b1;
        tick(k == 2 ? 30 : 1);
        wdt <= 1'b0;
        iwake <= 1'b0;
        clear_req <= 1'b0;
        tick(8);
        `CHK(cause, ec)
        `CHK({to_f, pd_f}, ef)
        `CHK(gcnt - c0, is_wake ? 0 : 1)
        `CHK(wcnt - c1, is_wake ? 1 : 0)
        `CHK(core_reset, (k == 1) ? 1'b1 : 1'b0)
        slp <= 1'b0;
        tick(1);
        wait_until(6000, 0, 0, c);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        int c;
        int lo;
        tick(16);
        `CHK({core_reset, lp, to_f, pd_f, dip_f}, 5'h1F)
        `CHK({por_f, cause, mc_oe}, 5'h0)
        reset_n <= 1'b1;
        tick(4);
        // Power-on in every mode and delay setting, timed to release.
        for (int i = 0; i < 6; i++)
        begin
            supply_up <= 1'b0;
            {sel_hi, sel_lo, dly_n, dip_en} <= tbl[i];
            tick(30);
            c = gcnt;
            supply_up <= 1'b1;
            wait_until(12, 1, c, c);
            `CHK({cause, to_f, pd_f, por_f, dip_f}, 7'h0D)
            wait_until(9000, 0, 0, c);
            lo = exp_delay(tbl[i]);
            `CHK(c >= lo - 8 && c <= lo + 12, 1'b1)
            `CHK(modes, 4'h1 << tbl[i][3:2])
        end
        // Random mode codes while running, ending in the resistor-capacitor mode.
        for (int i = 0; i < 8; i++)
        begin
            seed = xs(seed);
            {sel_hi, sel_lo} <= (i == 7) ? 2'h3 : seed[1:0];
            tick(3);
            `CHK(modes, 4'h1 << ((i == 7) ? 2'h3 : seed[1:0]))
        end
        swpor <= 1'b1;
        tick(1);
        swpor <= 1'b0;
        tick(2);
        `CHK(por_f, 1'b1)
        // A short random glitch on the pin must not reset.
        c = gcnt;
        seed = xs(seed);
        clear_req <= 1'b1;
        tick(2 + int'(seed % 12));
        clear_req <= 1'b0;
        tick(25);
        `CHK(gcnt, c)
        ev(1'b0, 0, `RSS_CAUSE_WDT_RUN, 2'h1, 0);
        ev(1'b1, 0, `RSS_CAUSE_WDT_WAKE, 2'h0, 1);
        {sel_hi, sel_lo} <= 2'h1;
        ev(1'b1, 1, `RSS_CAUSE_INT_WAKE, 2'h2, 1);
        {sel_hi, sel_lo} <= 2'h3;
        ev(1'b1, 2, `RSS_CAUSE_MASTER_CLEAR_PIN_SLP, 2'h2, 0);
        ev(1'b0, 2, `RSS_CAUSE_MASTER_CLEAR_PIN_RUN, 2'h2, 0);
        // Dips: ignored when disabled or short, then a restart inside the delay.
        c = gcnt;
        dip_en <= 1'b0;
        dip_req <= 1'b1;
        tick(20);
        dip_req <= 1'b0;
        dip_en <= 1'b1;
        tick(10);
        dip_req <= 1'b1;
        tick(3);
        dip_req <= 1'b0;
        tick(10);
        `CHK(gcnt, c)
        dip_req <= 1'b1;
        tick(20);
        `CHK({core_reset, cause, dip_f}, 5'h1A)
        dip_req <= 1'b0;
        tick(20);
        `CHK(core_reset, 1'b1)
        dip_req <= 1'b1;
        tick(20);
        dip_req <= 1'b0;
        wait_until(300, 0, 0, c);
        `CHK(c >= PW && c <= PW + 12, 1'b1)
        `CHK(por_f, 1'b1)
        conclude();
    end
endmodule
